// [hw/gpio_pkg.sv]
// Constants shared by the port block: register indices, field positions, reset values.
// Assumes the core reaches the registers over a simple index/strobe register port.
package gpio_pkg;
   // ==========================================================================
   // Register indices on the core register port
   localparam logic [2:0] idx_flags = 3'h0;
   localparam logic [2:0] idx_pc_enables = 3'h1;
   localparam logic [2:0] idx_output_value = 3'h2;
   localparam logic [2:0] idx_direction = 3'h3;
   localparam logic [2:0] idx_pin_sense = 3'h4;
   localparam logic [2:0] idx_irq_mask = 3'h5;
   localparam logic [2:0] idx_core_control = 3'h6;
   // ==========================================================================
   // Field positions
   localparam int ext_flag_bit = 6;
   localparam int pc_flag_bit = 5;
   localparam int ext_enable_bit = 6;
   localparam int pc_enable_bit = 5;
   localparam int pud_bit = 6;
   localparam int sense_hi_bit = 1;
   localparam int sense_lo_bit = 0;
   localparam int pc_mask_width = 6;
   // ==========================================================================
   // Reset values
   localparam logic [7:0] reg_reset = 8'h00;
   // Sense select encodings
   localparam logic [1:0] sense_low_level = 2'h0;
   localparam logic [1:0] sense_any_change = 2'h1;
   localparam logic [1:0] sense_falling = 2'h2;
   localparam logic [1:0] sense_rising = 2'h3;
endpackage

// [hw/pin_sync.sv]
// Two-stage pin synchroniser: latch open while clock is high, then a rising-edge flop.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
module pin_sync #(
   parameter int width = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Pin levels in, synchronised levels out
   input wire logic [width-1:0] pin_in,
   output logic [width-1:0] pin_sync_q
);
   logic [width-1:0] latch_q;

   // ==========================================================================
   // Latch stage, transparent while clock high
   always_latch
   begin
      // Non-blocking so the flop below still sees the closed-latch value at the rising edge
      if (!rstn)
         latch_q <= '0;
      else if (clock)
         latch_q <= pin_in;
   end

   // Register stage read only after latch; nothing else looks at latch_q
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pin_sync_q <= '0;
      else
         pin_sync_q <= latch_q;
   end
endmodule

// [hw/gpio_port.sv]
// General-purpose I/O port with external-pin and pin-change interrupt flags.
// Assumes a core register port (index, write strobe, read strobe) on the same clock.
//
// Operation
// - Selected edge/change on external pin sets external flag bit 6.
// - Low-level sense keeps the external flag at zero.
// - Change on a masked-in pin sets pin-change flag bit 5 while pin-change enable is set.
// - Interrupt requested only with global enable and source enable set.
// - Each flag clears when the core services its interrupt.
// - Writing one to a flag clears it; zero leaves it.
// - Flag register bits 7 and 4:0 read zero.
// - Mask bits 5:0 enable change detection per pin with pin-change enable.
// - Mask bits 7:6 read zero and ignore writes.
// - Direction one makes the pin an output, zero an input.
// - Pull-up on only for input, output value one, pull-up disable zero.
// - Global pull-up disable turns off all pull-ups.
// - Output pin driven to its output value bit.
// - Reset tri-states asynchronously every pin not driven by an alternate direction override.
// - Writing one to pin-sense register toggles the output value bit.
// - Pin-sense is read-only storage; output value and direction read/write.
// - Each toggle bit acts on its own; direction and value are byte writes, single bits by core read-modify-write.
// - Pin levels read through latch plus register synchroniser.
// - Written value visible in pin-sense one clock after reaching pin.
// - Alternate functions on some pins leave others as plain I/O.
// - Sense select: 00 low, 01 any change, 10 falling, 11 rising.
// - Pin-change requests detected without needing the I/O clock.
`timescale 1ns/1ps
module gpio_port #(
   parameter int pins = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Core register port
   input wire logic [2:0] reg_index,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Core interrupt side
   input wire logic global_irq_enable,
   input wire logic ext_irq_ack,
   input wire logic pc_irq_ack,
   output logic ext_irq_req,
   output logic pc_irq_req,
   // Alternate function overrides, per pin
   input wire logic [pins-1:0] alt_dir_override_en,
   input wire logic [pins-1:0] alt_dir_override_val,
   input wire logic [pins-1:0] alt_val_override_en,
   input wire logic [pins-1:0] alt_val_override_val,
   // Pads
   input wire logic [pins-1:0] pad_in,
   output logic [pins-1:0] pad_out,
   output logic [pins-1:0] pad_oe_n,
   output logic [pins-1:0] pad_pullup,
   // External interrupt pin selection
   input wire logic [2:0] ext_pin_select
);
   logic [7:0] output_value_q;
   logic [7:0] direction_q;
   logic [7:0] pc_enables_q;
   logic [7:0] irq_mask_q;
   logic [7:0] core_control_q;
   logic ext_flag_q;
   logic pc_flag_q;
   logic ext_prev_q;
   logic [pins-1:0] pc_prev_q;
   logic [pins-1:0] pin_sense;
   logic [pins-1:0] drive_en;
   logic [pins-1:0] drive_val;
   logic [1:0] sense_sel;
   logic ext_level;
   logic ext_event;
   logic pc_event;
   logic pc_async_seen;
   logic global_pullup_disable;
   logic wr_flags;

   // ==========================================================================
   // Pin synchroniser
   pin_sync #(.width(pins)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .pin_in(pad_in),
      .pin_sync_q(pin_sense)
   );

   // ==========================================================================
   // Control registers
   assign global_pullup_disable = core_control_q[gpio_pkg::pud_bit];
   assign sense_sel = {core_control_q[gpio_pkg::sense_hi_bit],
                       core_control_q[gpio_pkg::sense_lo_bit]};

   // Direction register, plain byte write; single-bit ops are core read-modify-write
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         direction_q <= gpio_pkg::reg_reset;
      else if (reg_write && reg_index == gpio_pkg::idx_direction)
         direction_q <= reg_wdata;
   end

   // Output value: direct write or toggle by writing ones to pin-sense
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         output_value_q <= gpio_pkg::reg_reset;
      else if (reg_write && reg_index == gpio_pkg::idx_output_value)
         output_value_q <= reg_wdata;
      else if (reg_write && reg_index == gpio_pkg::idx_pin_sense)
         output_value_q <= output_value_q ^ reg_wdata;
   end

   // Pin-change mask, reserved bits never stored
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pc_enables_q <= gpio_pkg::reg_reset;
      else if (reg_write && reg_index == gpio_pkg::idx_pc_enables)
         pc_enables_q <= {2'h0, reg_wdata[gpio_pkg::pc_mask_width-1:0]};
   end

   // Interrupt enable mask and core control
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_mask_q <= gpio_pkg::reg_reset;
         core_control_q <= gpio_pkg::reg_reset;
      end
      else if (reg_write && reg_index == gpio_pkg::idx_irq_mask)
         irq_mask_q <= reg_wdata & 8'h60;
      else if (reg_write && reg_index == gpio_pkg::idx_core_control)
         core_control_q <= reg_wdata & 8'h7b;
   end

   // ==========================================================================
   // Pad drive; alternate overrides are per pin so other pins stay plain I/O
   always_comb
   begin
      for (int i = 0; i < pins; i++)
      begin
         drive_en[i] = alt_dir_override_en[i] ? alt_dir_override_val[i]
                                              : direction_q[i];
         drive_val[i] = alt_val_override_en[i] ? alt_val_override_val[i]
                                               : output_value_q[i];
      end
   end

   // Reset clears the registers asynchronously, so pads without an alternate direction override float without a clock
   assign pad_oe_n = ~drive_en;
   assign pad_out = drive_val & drive_en;
   assign pad_pullup = ~drive_en & output_value_q[pins-1:0] & {pins{~global_pullup_disable}};

   // ==========================================================================
   // External interrupt detection on the synchronised sample
   assign ext_level = pin_sense[ext_pin_select];

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ext_prev_q <= 1'b0;
      else
         ext_prev_q <= ext_level;
   end

   // Sense encoding; low level raises the request directly, not the flag
   always_comb
   begin
      case (sense_sel)
         gpio_pkg::sense_any_change: ext_event = ext_level ^ ext_prev_q;
         gpio_pkg::sense_falling: ext_event = ext_prev_q & ~ext_level;
         gpio_pkg::sense_rising: ext_event = ~ext_prev_q & ext_level;
         default: ext_event = 1'b0;
      endcase
   end

   // ==========================================================================
   // Pin-change detection: async toggle capture so changes count with clock stopped
   genvar g;
   logic [pins-1:0] pc_seen;
   for (g = 0; g < pins; g++)
   begin : g_pc
      logic raw;
      assign raw = pad_in[g] & pc_enables_q[g];
      // Sets on either pad edge; latches a change without a running clock
      always_latch
      begin
         if (!rstn)
            pc_seen[g] = 1'b0;
         else if (raw != pc_prev_q[g])
            pc_seen[g] = 1'b1;
         else if (!clock)
            pc_seen[g] = 1'b0;
      end
   end
   assign pc_async_seen = |pc_seen;

   // Synchronised change compare; reference tracks the masked level
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pc_prev_q <= '0;
      else
         pc_prev_q <= pin_sense & pc_enables_q[pins-1:0];
   end
   assign pc_event = |((pin_sense & pc_enables_q[pins-1:0]) ^ pc_prev_q)
                     & irq_mask_q[gpio_pkg::pc_enable_bit];

   // ==========================================================================
   // Flags: event set wins over write-one and acknowledge clears
   assign wr_flags = reg_write && reg_index == gpio_pkg::idx_flags;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ext_flag_q <= 1'b0;
      else if (sense_sel == gpio_pkg::sense_low_level)
         ext_flag_q <= 1'b0;
      else if (ext_event)
         ext_flag_q <= 1'b1;
      else if (ext_irq_ack || (wr_flags && reg_wdata[gpio_pkg::ext_flag_bit]))
         ext_flag_q <= 1'b0;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         pc_flag_q <= 1'b0;
      else if (pc_event)
         pc_flag_q <= 1'b1;
      else if (pc_irq_ack || (wr_flags && reg_wdata[gpio_pkg::pc_flag_bit]))
         pc_flag_q <= 1'b0;
   end

   // Requests to the core; low level requests while the pin is held low
   assign ext_irq_req = global_irq_enable & irq_mask_q[gpio_pkg::ext_enable_bit]
                        & (ext_flag_q | (sense_sel == gpio_pkg::sense_low_level
                                         & ~ext_level));
   // Async capture lets a pin change raise the request with the I/O clock stopped
   assign pc_irq_req = global_irq_enable & irq_mask_q[gpio_pkg::pc_enable_bit]
                       & (pc_flag_q | pc_async_seen);

   // ==========================================================================
   // Read data, registered, held until the next read
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= gpio_pkg::reg_reset;
      else if (reg_read)
      begin
         if (reg_index == gpio_pkg::idx_flags)
            reg_rdata <= {1'b0, ext_flag_q, pc_flag_q, 5'h00};
         else if (reg_index == gpio_pkg::idx_pc_enables)
            reg_rdata <= pc_enables_q;
         else if (reg_index == gpio_pkg::idx_output_value)
            reg_rdata <= output_value_q;
         else if (reg_index == gpio_pkg::idx_direction)
            reg_rdata <= direction_q;
         else if (reg_index == gpio_pkg::idx_pin_sense)
            reg_rdata <= {{(8-pins){1'b0}}, pin_sense};
         else if (reg_index == gpio_pkg::idx_irq_mask)
            reg_rdata <= irq_mask_q;
         else if (reg_index == gpio_pkg::idx_core_control)
            reg_rdata <= core_control_q;
         else
            reg_rdata <= gpio_pkg::reg_reset;
      end
   end
endmodule

// [verification/gpio_port_checker.sv]
// Assertions on the port block, bound to its top module.
// Assumes one clock domain and the registered read data of the register port.
`timescale 1ns/1ps
module gpio_port_checker #(
   parameter int pins = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register port
   input wire logic [2:0] reg_index,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Interrupt side
   input wire logic global_irq_enable,
   input wire logic pc_irq_ack,
   input wire logic ext_irq_req,
   input wire logic pc_irq_req,
   // Pads
   input wire logic [pins-1:0] pad_in,
   input wire logic [pins-1:0] pad_out,
   input wire logic [pins-1:0] pad_oe_n,
   input wire logic [pins-1:0] pad_pullup
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic [2:0] quiet_q;
   logic [pins-1:0] pad_prev_q;
   // ==========================================================================
   // Quiet counter: edges still in the synchroniser make a check unsafe
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         quiet_q <= 3'h0;
         pad_prev_q <= '0;
      end
      else
      begin
         pad_prev_q <= pad_in;
         if (pad_in != pad_prev_q || reg_write)
            quiet_q <= 3'h0;
         else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
      end
   end
   // ==========================================================================
   // Properties
   reset_tristate_a: assert property (disable iff (1'b0) !rstn |-> &pad_oe_n)
      else $error("pads driven during reset");
   pullup_drive_a: assert property ((~pad_oe_n & pad_pullup) == '0)
      else $error("pull-up on a driven pad");
   req_gate_a: assert property ((ext_irq_req || pc_irq_req) |-> global_irq_enable)
      else $error("request without global enable");
   pc_ack_a: assert property (pc_irq_ack && quiet_q == 3'h7 |=> !pc_irq_req)
      else $error("acknowledge left pin-change request");
   rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   flag_rsvd_a: assert property (reg_read && reg_index == gpio_pkg::idx_flags
      |=> (reg_rdata & 8'h9f) == 8'h00) else $error("flag spare bits not zero");
   mask_rsvd_a: assert property (reg_read && reg_index == gpio_pkg::idx_pc_enables
      |=> reg_rdata[7:6] == 2'h0) else $error("mask spare bits not zero");
   pin_read_a: assert property (reg_read && reg_index == gpio_pkg::idx_pin_sense
      && quiet_q == 3'h7 |=> reg_rdata[pins-1:0] == $past(pad_in))
      else $error("pin sense differs from settled pads");
   toggle_a: assert property (reg_write && reg_index == gpio_pkg::idx_pin_sense
      && pad_oe_n == '0 |=> (pad_out ^ $past(reg_wdata[pins-1:0])) == $past(pad_out))
      else $error("toggle write did not invert drive");
   // Main scenarios reached
   pc_seen_c: cover property (pc_irq_req);
   ext_seen_c: cover property (ext_irq_req);
   toggle_c: cover property (reg_write && reg_index == gpio_pkg::idx_pin_sense);
endmodule

// [verification/board_model.sv]
// Board circuitry on the pads: external drivers, pull-ups, floating pins.
// Assumes the chip drives a pad whenever its active-low enable is low.
`timescale 1ns/1ps
module board_model #(
   parameter int pins = 6
) (
   // Clock for the floating pattern
   input wire logic clock,
   // Chip side of the pads
   input wire logic [pins-1:0] pad_out,
   input wire logic [pins-1:0] pad_oe_n,
   input wire logic [pins-1:0] pad_pullup,
   // Board drivers and resolved levels
   input wire logic [pins-1:0] ext_en,
   input wire logic [pins-1:0] ext_val,
   output logic [pins-1:0] pad_level
);
   logic [pins-1:0] float_q = '0;
   // Undriven pads wander so a stale level is never read back
   always_ff @(posedge clock)
      float_q <= ~float_q;
   // Chip driver wins, then board drivers, then the pull-up
   always_comb
      for (int i = 0; i < pins; i++)
         pad_level[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i]
            : pad_pullup[i] ? 1'b1 : float_q[i];
endmodule

// [verification/gpio_port_tb.sv]
// Self-checking bench for the port block with a board model on its pads.
// Assumes the register indices of the package and a 200 MHz clock.
`timescale 1ns/1ps
module gpio_port_with_pin_change_irq_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] reg_index = 3'h0;
   logic reg_write = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic global_irq_enable = 1'b0;
   logic ext_irq_ack = 1'b0;
   logic pc_irq_ack = 1'b0;
   logic ext_irq_req;
   logic pc_irq_req;
   logic [5:0] pad_in;
   logic [5:0] pad_out;
   logic [5:0] pad_oe_n;
   logic [5:0] pad_pullup;
   logic [5:0] ext_en = 6'h00;
   logic [5:0] ext_val = 6'h00;
   logic [5:0] alt_en = 6'h00;
   logic [5:0] alt_val = 6'h00;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   // ==========================================================================
   // Clock, hang guard, design and board
   always #2.5 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         finish_test();
      end
   end
   gpio_port i_gpio_port (.clock(clock), .rstn(rstn), .reg_index(reg_index),
      .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
      .ext_irq_ack(ext_irq_ack), .pc_irq_ack(pc_irq_ack), .ext_irq_req(ext_irq_req),
      .pc_irq_req(pc_irq_req), .alt_dir_override_en(alt_en), .alt_dir_override_val(alt_val),
      .alt_val_override_en(alt_en), .alt_val_override_val(alt_val), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
      .ext_pin_select(3'h2));
   board_model i_board_model (.clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));
   // ==========================================================================
   // Shared tasks; strobes move at the falling edge
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      if (got !== exp)
         bad_count++;
   endtask
   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      @(negedge clock);
      reg_index = idx;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
   endtask
   task automatic rdc(input logic [2:0] idx, input logic [7:0] exp, input logic [7:0] m = 8'hff);
      @(negedge clock);
      reg_index = idx;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      @(negedge clock);
      chk(reg_rdata & m, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic finish_test;
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset;
      rdc(gpio_pkg::idx_flags, 8'h00);
      rdc(gpio_pkg::idx_direction, 8'h00);
      rdc(3'h7, 8'h00);
      wr(gpio_pkg::idx_direction, 8'h3f);
      chk({2'h0, pad_oe_n}, 8'h00);
      #1 rstn = 1'b0;
      #1 chk({2'h0, pad_oe_n}, 8'h3f);
      @(negedge clock);
      rstn = 1'b1;
   endtask
   task automatic t_pins;
      logic d, v, u;
      for (int i = 0; i < 8; i++)
      begin
         {d, v, u} = i[2:0];
         // Value before direction, so 00 and 11 never meet directly
         wr(gpio_pkg::idx_core_control, {1'b0, u, 6'h00});
         wr(gpio_pkg::idx_output_value, {2'h0, {6{v}}});
         wr(gpio_pkg::idx_direction, {2'h0, {6{d}}});
         chk({2'h0, pad_oe_n}, {2'h0, {6{!d}}});
         chk({2'h0, pad_out}, {2'h0, {6{d & v}}});
         chk({2'h0, pad_pullup}, {2'h0, {6{!d & v & !u}}});
      end
   endtask
   task automatic t_toggle;
      wr(gpio_pkg::idx_output_value, 8'h05);
      wr(gpio_pkg::idx_pin_sense, 8'h03);
      rdc(gpio_pkg::idx_output_value, 8'h06);
      wr(gpio_pkg::idx_pin_sense, 8'h20);
      rdc(gpio_pkg::idx_pin_sense, 8'h26, 8'h3f);
      // Settled pads let the checker compare pin sense with the pad levels
      wait_n(8);
      rdc(gpio_pkg::idx_pin_sense, 8'h26, 8'h3f);
      wr(gpio_pkg::idx_direction, 8'h00);
      wr(gpio_pkg::idx_pin_sense, 8'h01);
      rdc(gpio_pkg::idx_output_value, 8'h27);
   endtask
   task automatic t_pcint;
      ext_en = 6'h3f;
      wr(gpio_pkg::idx_irq_mask, 8'h20);
      wr(gpio_pkg::idx_pc_enables, 8'hff);
      rdc(gpio_pkg::idx_pc_enables, 8'h3f);
      wr(gpio_pkg::idx_flags, 8'h60);
      global_irq_enable = 1'b1;
      ext_val = 6'h02;
      wait_n(10);
      chk({7'h0, pc_irq_req}, 8'h01);
      rdc(gpio_pkg::idx_flags, 8'h20);
      global_irq_enable = 1'b0;
      #1 chk({7'h0, pc_irq_req}, 8'h00);
      wr(gpio_pkg::idx_flags, 8'h40);
      rdc(gpio_pkg::idx_flags, 8'h20);
      wr(gpio_pkg::idx_flags, 8'h20);
      rdc(gpio_pkg::idx_flags, 8'h00);
      global_irq_enable = 1'b1;
      ext_val = 6'h00;
      wait_n(10);
      pc_irq_ack = 1'b1;
      @(negedge clock);
      pc_irq_ack = 1'b0;
      rdc(gpio_pkg::idx_flags, 8'h00);
      wr(gpio_pkg::idx_pc_enables, 8'h3d);
      ext_val = 6'h02;
      wait_n(6);
      rdc(gpio_pkg::idx_flags, 8'h00);
      ext_val = 6'h00;
   endtask
   task automatic t_ext;
      logic [3:0] rise_e, fall_e;
      rise_e = 4'ha;
      fall_e = 4'h6;
      wr(gpio_pkg::idx_pc_enables, 8'h00);
      wr(gpio_pkg::idx_irq_mask, 8'h40);
      for (int m = 0; m < 4; m++)
      begin
         wr(gpio_pkg::idx_core_control, {6'h00, m[1:0]});
         wr(gpio_pkg::idx_flags, 8'h60);
         ext_val = 6'h04;
         wait_n(6);
         chk({7'h0, ext_irq_req}, {7'h0, rise_e[m]});
         rdc(gpio_pkg::idx_flags, {1'b0, rise_e[m], 6'h00});
         wr(gpio_pkg::idx_flags, 8'h60);
         ext_val = 6'h00;
         wait_n(6);
         rdc(gpio_pkg::idx_flags, {1'b0, fall_e[m], 6'h00});
      end
      ext_val = 6'h04;
      wait_n(6);
      ext_irq_ack = 1'b1;
      @(negedge clock);
      ext_irq_ack = 1'b0;
      rdc(gpio_pkg::idx_flags, 8'h00);
   endtask
   // Override on pin 0 only; other pins keep their register settings
   task automatic t_alt;
      alt_en = 6'h01;
      alt_val = 6'h01;
      #1 chk({2'h0, pad_oe_n}, 8'h3e);
      chk({2'h0, pad_out}, 8'h01);
      chk({2'h0, pad_pullup}, 8'h26);
      @(negedge clock);
      alt_en = 6'h00;
      alt_val = 6'h00;
      #1 chk({2'h0, pad_oe_n}, 8'h3f);
   endtask
   // Main sequence after 20 cycles of reset
   initial
   begin
      wait_n(20);
      rstn = 1'b1;
      t_reset();
      t_pins();
      t_toggle();
      t_pcint();
      t_ext();
      t_alt();
      finish_test();
   end
endmodule
bind gpio_port gpio_port_checker #(.pins(pins)) i_gpio_port_checker (.clock(clock),
   .rstn(rstn), .reg_index(reg_index), .reg_write(reg_write), .reg_wdata(reg_wdata),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
   .pc_irq_ack(pc_irq_ack), .ext_irq_req(ext_irq_req), .pc_irq_req(pc_irq_req),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup));
